/* File: interp_cmd_pkg.sv */
/*
 * Constants, field positions, reset values and types for the command
 * strobes and first configuration word of the interpolator control block.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package interp_cmd_pkg;

    // ************************************************************
    // Command strobe bit positions
    // ************************************************************
    localparam int CMD_WIDTH            = 8;
    localparam int CMD_CAL_REFRESH_BIT  = 7;
    localparam int CMD_VERNIER_BIT      = 6;
    localparam int CMD_LATCH_ADDR_BIT   = 5;
    localparam int CMD_STORE_BIT        = 4;
    localparam int CMD_REINIT_BIT       = 3;
    localparam int CMD_CLEAR_INDEX_BIT  = 2;
    localparam int CMD_LOOP_RESET_BIT   = 1;
    localparam int CMD_RELOAD_BIT       = 0;

    // ************************************************************
    // First configuration word fields
    // ************************************************************
    localparam int CFG_WIDTH            = 32;
    localparam int CFG_TRISTATE_BIT     = 31;
    localparam int CFG_VERNIER_LATCH_BIT = 30;
    localparam int CFG_OFFSET_LATCH_BIT = 29;
    localparam int CFG_FREEZE_SEL_BIT   = 23;
    localparam logic [31:0] CFG_ONE_RESET = 32'h00f7_0000;

    // ************************************************************
    // Other widths and reset values
    // ************************************************************
    localparam int ADDR_WIDTH           = 4;
    localparam logic [3:0] ADDR_RESET   = 4'h0;
    localparam int CORR_WIDTH           = 8;

    typedef enum logic [1:0] {
        TRIG_OFF,
        TRIG_EDGE,
        TRIG_ADJUST_Z,
        TRIG_DISTANCE_CODED
    } trigger_mode_t;

endpackage

/* File: cmd_strobe_if.sv */
/*
 * Carrier of the one-cycle command strobes from the decoder to the
 * block's own logic.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none

interface cmd_strobe_if
    import interp_cmd_pkg::*;
();
    logic [CMD_WIDTH-1:0] strobe;

    modport decoder (output strobe);
    modport user    (input  strobe);
endinterface

`default_nettype wire

/* File: cmd_strobe_decoder.sv */
/*
 * Turns a write of the command register into one-cycle strobes.
 * Assumes the serial port presents each completed register write as a
 * single-cycle write pulse with its data, synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module cmd_strobe_decoder
    import interp_cmd_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 write_in,
    input  wire logic [CMD_WIDTH-1:0] data_in,
    cmd_strobe_if.decoder             strobes
);

    // RQ17 strobes not retained
    // Only written ones fire, and each for exactly one cycle.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            strobes.strobe <= '0;
        else if (write_in)
            strobes.strobe <= data_in;
        else
            strobes.strobe <= '0;
    end

endmodule

`default_nettype wire

/* File: fault_output_ctrl.sv */
/*
 * Vernier and offset fault latching and the square-wave output stage.
 * Assumes the raw fault inputs are levels from the detectors and that the
 * pad logic resolves the output enable.
 */
`timescale 1ns/1ps
`default_nettype none

module fault_output_ctrl
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       vernier_fault_in,
    input  wire logic       offset_fault_in,
    input  wire logic       other_fault_in,
    input  wire logic       vernier_fault_latch_en_in,
    input  wire logic       offset_fault_latch_en_in,
    input  wire logic       tristate_sel_in,
    input  wire logic       fault_output_freeze_sel_in,
    input  wire logic       clear_faults_in,
    input  wire logic [2:0] abz_in,
    output logic            vernier_fault_out,
    output logic            offset_fault_out,
    output logic            error_out,
    output logic      [2:0] abz_out,
    output logic      [2:0] abz_oe_out
);

    logic vernier_held;
    logic offset_held;

    // ************************************************************
    // Fault latching
    // ************************************************************

    // RQ14 vernier fault keep
    // A new fault wins over a clear in the same cycle.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            vernier_held <= 1'b0;
        else if (vernier_fault_in && vernier_fault_latch_en_in)
            vernier_held <= 1'b1;
        else if (clear_faults_in || !vernier_fault_latch_en_in)
            vernier_held <= 1'b0;
    end

    // RQ15 offset fault keep
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            offset_held <= 1'b0;
        else if (offset_fault_in && offset_fault_latch_en_in)
            offset_held <= 1'b1;
        else if (clear_faults_in || !offset_fault_latch_en_in)
            offset_held <= 1'b0;
    end

    always_comb
    begin
        vernier_fault_out = vernier_held | vernier_fault_in;
        offset_fault_out  = offset_held | offset_fault_in;
        error_out         = vernier_fault_out | offset_fault_out | other_fault_in;
    end

    // ************************************************************
    // Square-wave output stage
    // ************************************************************

    // RQ13 tristate on error
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            abz_oe_out <= 3'h0;
        else if (error_out && tristate_sel_in)
            abz_oe_out <= 3'h0;
        else
            abz_oe_out <= 3'h7;
    end

    // RQ16 freeze on error
    // With freeze deselected the outputs simply keep following the input.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            abz_out <= 3'h0;
        else if (!(error_out && !tristate_sel_in && fault_output_freeze_sel_in))
            abz_out <= abz_in;
    end

endmodule

`default_nettype wire

/* File: interpolator_command_strobes.sv */
/*
 * Command interpreter and first configuration word of the interpolator.
 * Assumes the serial host port delivers completed register writes as
 * single-cycle pulses, and that the datapaths outside act on the
 * one-cycle request pulses given here.
 */
// Notes on behaviour
// RQ1 - Calibration refresh on command bit 7, and while the trigger pin is active.
// RQ2 - Command bit 6 recomputes vernier offset from second preload and stores it.
// RQ3 - Vernier recompute only acts while preload enable is set; host sets it first.
// RQ4 - Command bit 5 samples the four address straps as the bus address.
// RQ5 - Host sends address latch to all devices before addressing any one.
// RQ6 - Initialisation latches the address automatically in serial sensor mode.
// RQ7 - Command bit 4 stores configuration, loop initials and preloads to memory.
// RQ8 - Command bit 3 resets the chip internally and reloads configuration.
// RQ9 - Command bit 2 clears index flag; starts measurement in two trigger modes.
// RQ10 - Command bit 1 resets correction loop, values go to range midpoint.
// RQ11 - Command bit 0 loads both position counters from their preloads.
// RQ12 - Counter reload also clears error flags, index flag, may start measurement.
// RQ13 - Config bit 31 set tristates A, B, Z on error; else freeze bit rules.
// RQ14 - Config bit 30, reset 0, keeps vernier faults when set.
// RQ15 - Config bit 29, reset 0, keeps offset faults when set.
// RQ16 - Freeze bit set holds A, B, Z during error when not tristated.
// RQ17 - Zero command bits do nothing; strobes last one cycle; command reads zero.
`timescale 1ns/1ps
`default_nettype none

module interpolator_command_strobes
    import interp_cmd_pkg::*;
#(
    parameter int CORR_BITS = CORR_WIDTH
)
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 cmd_write_in,
    input  wire logic [CMD_WIDTH-1:0] cmd_data_in,
    output logic      [CMD_WIDTH-1:0] cmd_read_data_out,
    input  wire logic                 cfg_write_in,
    input  wire logic [CFG_WIDTH-1:0] cfg_data_in,
    output logic      [CFG_WIDTH-1:0] config_word_one_out,
    input  wire logic                 preload_function_enable_in,
    input  wire logic                 external_trigger_pin_in,
    input  wire logic           [3:0] address_strap_in,
    input  wire logic                 init_pulse_in,
    input  wire logic                 serial_sensor_mode_in,
    input  wire trigger_mode_t        trigger_mode_in,
    input  wire logic                 index_event_in,
    input  wire logic                 vernier_fault_in,
    input  wire logic                 offset_fault_in,
    input  wire logic                 other_fault_in,
    input  wire logic           [2:0] abz_in,
    output logic                      calibration_refresh_out,
    output logic                      vernier_recompute_out,
    output logic     [ADDR_WIDTH-1:0] bus_address_out,
    output logic                      store_settings_out,
    output logic                      chip_reinit_out,
    output logic                      config_reload_out,
    output logic                      index_seen_flag_out,
    output logic                      measurement_start_out,
    output logic                      correction_loop_reset_out,
    output logic      [CORR_BITS-1:0] gain_correction_out,
    output logic      [CORR_BITS-1:0] offset_correction_out,
    output logic                      counter_reload_out,
    output logic                      clear_faults_out,
    output logic                      vernier_fault_out,
    output logic                      offset_fault_out,
    output logic                      error_out,
    output logic                [2:0] abz_out,
    output logic                [2:0] abz_oe_out
);

    localparam logic [CORR_BITS-1:0] CORR_MID = {1'b1, {(CORR_BITS-1){1'b0}}};

    cmd_strobe_if strobes ();

    logic cal_strobe;
    logic vernier_strobe;
    logic addr_strobe;
    logic store_strobe;
    logic reinit_strobe;
    logic clear_index_strobe;
    logic loop_strobe;
    logic reload_strobe;
    logic index_clear;
    logic measure_mode;

    // ************************************************************
    // Command decode
    // ************************************************************
    cmd_strobe_decoder u_decoder (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .write_in (cmd_write_in),
        .data_in  (cmd_data_in),
        .strobes  (strobes.decoder)
    );

    always_comb
    begin
        cal_strobe         = strobes.strobe[CMD_CAL_REFRESH_BIT];
        vernier_strobe     = strobes.strobe[CMD_VERNIER_BIT];
        addr_strobe        = strobes.strobe[CMD_LATCH_ADDR_BIT];
        store_strobe       = strobes.strobe[CMD_STORE_BIT];
        reinit_strobe      = strobes.strobe[CMD_REINIT_BIT];
        clear_index_strobe = strobes.strobe[CMD_CLEAR_INDEX_BIT];
        loop_strobe        = strobes.strobe[CMD_LOOP_RESET_BIT];
        reload_strobe      = strobes.strobe[CMD_RELOAD_BIT];
        measure_mode       = (trigger_mode_in == TRIG_ADJUST_Z) ||
                             (trigger_mode_in == TRIG_DISTANCE_CODED);
        index_clear        = clear_index_strobe | reload_strobe;
    end

    // RQ17 write-only register
    assign cmd_read_data_out = '0;

    // ************************************************************
    // Request pulses
    // ************************************************************
    always_comb
    begin
        // RQ1 refresh on trigger
        calibration_refresh_out   = cal_strobe | external_trigger_pin_in;
        // RQ2 vernier recompute, gated
        // RQ3 preload enable gate
        vernier_recompute_out     = vernier_strobe & preload_function_enable_in;
        // RQ7 store settings
        store_settings_out        = store_strobe;
        // RQ8 internal chip reset
        chip_reinit_out           = reinit_strobe;
        // RQ10 loop reset request
        correction_loop_reset_out = loop_strobe;
        // RQ11 counter load request
        counter_reload_out        = reload_strobe;
        // RQ12 clear all faults
        clear_faults_out          = reload_strobe;
        // RQ9 new measurement start
        measurement_start_out     = index_clear & measure_mode;
    end

    // ************************************************************
    // Address, index flag and correction values
    // ************************************************************

    // RQ4 sample address straps
    // RQ6 latch at initialisation
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            bus_address_out <= ADDR_RESET;
        else if (addr_strobe || (init_pulse_in && serial_sensor_mode_in))
            bus_address_out <= address_strap_in;
    end

    // RQ9 clear index flag
    // A new index event wins over a clear in the same cycle.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            index_seen_flag_out <= 1'b0;
        else if (index_event_in)
            index_seen_flag_out <= 1'b1;
        else if (index_clear)
            index_seen_flag_out <= 1'b0;
    end

    // RQ10 corrections to midpoint
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            gain_correction_out   <= CORR_MID;
            offset_correction_out <= CORR_MID;
        end
        else if (loop_strobe || reinit_strobe)
        begin
            gain_correction_out   <= CORR_MID;
            offset_correction_out <= CORR_MID;
        end
    end

    // ************************************************************
    // First configuration word
    // ************************************************************

    // RQ8 reload configuration
    // A reinit returns the word to its reset value and asks for a reload.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            config_word_one_out <= CFG_ONE_RESET;
        else if (reinit_strobe)
            config_word_one_out <= CFG_ONE_RESET;
        else if (cfg_write_in)
            config_word_one_out <= cfg_data_in;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            config_reload_out <= 1'b0;
        else
            config_reload_out <= reinit_strobe;
    end

    // ************************************************************
    // Faults and output stage
    // ************************************************************
    fault_output_ctrl u_faults (
        .clk_in                     (clk_in),
        .reset_in                   (reset_in),
        .vernier_fault_in           (vernier_fault_in),
        .offset_fault_in            (offset_fault_in),
        .other_fault_in             (other_fault_in),
        .vernier_fault_latch_en_in  (config_word_one_out[CFG_VERNIER_LATCH_BIT]),
        .offset_fault_latch_en_in   (config_word_one_out[CFG_OFFSET_LATCH_BIT]),
        .tristate_sel_in            (config_word_one_out[CFG_TRISTATE_BIT]),
        .fault_output_freeze_sel_in (config_word_one_out[CFG_FREEZE_SEL_BIT]),
        .clear_faults_in            (reload_strobe),
        .abz_in                     (abz_in),
        .vernier_fault_out          (vernier_fault_out),
        .offset_fault_out           (offset_fault_out),
        .error_out                  (error_out),
        .abz_out                    (abz_out),
        .abz_oe_out                 (abz_oe_out)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    strobe_one_cycle_a: assert property (       // RQ17
        cmd_write_in |=> (strobes.strobe == $past(cmd_data_in))
                         ##1 (strobes.strobe == '0) || $past(cmd_write_in))
        else $error("Command strobe wrong or retained.");

    cal_refresh_a: assert property (            // RQ1
        (cmd_write_in && cmd_data_in[CMD_CAL_REFRESH_BIT]) |=> calibration_refresh_out)
        else $error("Calibration refresh missing.");

    vernier_gate_a: assert property (           // RQ3
        vernier_recompute_out |-> preload_function_enable_in && vernier_strobe)
        else $error("Vernier recompute without enable.");

    addr_latch_a: assert property (             // RQ4
        (cmd_write_in && cmd_data_in[CMD_LATCH_ADDR_BIT]) ##1 1
        |=> bus_address_out == $past(address_strap_in))
        else $error("Address straps not latched.");

    init_latch_a: assert property (             // RQ6
        (init_pulse_in && serial_sensor_mode_in) |=> bus_address_out == $past(address_strap_in))
        else $error("Address not latched at initialisation.");

    index_clear_a: assert property (            // RQ9
        (index_clear && !index_event_in) |=> !index_seen_flag_out)
        else $error("Index flag not cleared.");

    index_set_wins_a: assert property (         // RQ9
        index_event_in |=> index_seen_flag_out)
        else $error("Index event lost.");

    loop_mid_a: assert property (               // RQ10
        loop_strobe |=> (gain_correction_out == CORR_MID) &&
                        (offset_correction_out == CORR_MID))
        else $error("Corrections not at midpoint.");

    reload_clear_a: assert property (           // RQ12
        (cmd_write_in && cmd_data_in[CMD_RELOAD_BIT]) |=> clear_faults_out && counter_reload_out)
        else $error("Counter reload did not clear faults.");

    tristate_err_a: assert property (           // RQ13
        (error_out && config_word_one_out[CFG_TRISTATE_BIT]) |=> abz_oe_out == 3'h0)
        else $error("Outputs not released on error.");

    freeze_err_a: assert property (             // RQ16
        (error_out && !config_word_one_out[CFG_TRISTATE_BIT] &&
         config_word_one_out[CFG_FREEZE_SEL_BIT]) |=> $stable(abz_out))
        else $error("Outputs changed during error.");

    vernier_keep_a: assert property (           // RQ14
        (vernier_fault_in && config_word_one_out[CFG_VERNIER_LATCH_BIT] && !cfg_write_in &&
         !reinit_strobe) ##1 (!vernier_fault_in && !reload_strobe) |-> vernier_fault_out)
        else $error("Vernier fault not kept.");

    offset_keep_a: assert property (            // RQ15
        (offset_fault_in && config_word_one_out[CFG_OFFSET_LATCH_BIT] && !cfg_write_in &&
         !reinit_strobe) ##1 (!offset_fault_in && !reload_strobe) |-> offset_fault_out)
        else $error("Offset fault not kept.");

    reinit_cfg_a: assert property (             // RQ8
        reinit_strobe |=> config_reload_out && (config_word_one_out == CFG_ONE_RESET))
        else $error("Reinit did not reload configuration.");

    cover_measure_c: cover property (measurement_start_out);
    cover_address_c: cover property (addr_strobe ##1 bus_address_out != ADDR_RESET);
    cover_tristate_c: cover property (error_out ##1 abz_oe_out == 3'h0);
    cover_vernier_c: cover property (vernier_recompute_out);

endmodule

`default_nettype wire

/* File: host_port_model.sv */
/*
 * Behavioural host on the serial port: issues command and configuration
 * writes as single-cycle pulses.
 * Assumes the clock of the interpolator control block.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_model
    import interp_cmd_pkg::*;
(
    input  wire logic                 clk_in,
    output logic                      cmd_write_out,
    output logic      [CMD_WIDTH-1:0] cmd_data_out,
    output logic                      cfg_write_out,
    output logic      [CFG_WIDTH-1:0] cfg_data_out
);
    initial
    begin
        cmd_write_out = 1'b0;
        cmd_data_out  = 8'h00;
        cfg_write_out = 1'b0;
        cfg_data_out  = 32'h0000_0000;
    end

    // host ordering duties
    // Callers latch addresses and set preload enable before dependent commands.
    // Released data lines show the inverse so stale values never look valid.
    task automatic send_cmd(input logic [CMD_WIDTH-1:0] d);
        @(posedge clk_in);
        cmd_write_out <= 1'b1;
        cmd_data_out  <= d;
        @(posedge clk_in);
        cmd_write_out <= 1'b0;
        cmd_data_out  <= ~d;
    endtask

    task automatic send_cfg(input logic [CFG_WIDTH-1:0] d);
        @(posedge clk_in);
        cfg_write_out <= 1'b1;
        cfg_data_out  <= d;
        @(posedge clk_in);
        cfg_write_out <= 1'b0;
        cfg_data_out  <= ~d;
    endtask
endmodule

`default_nettype wire

/* File: interpolator_command_strobes_bench.sv */
/*
 * Self-checking bench for the command interpreter and first config word.
 * Assumes the host model above and the design package.
 */
`timescale 1ns/1ps
`default_nettype none

module interpolator_command_strobes_bench
    import interp_cmd_pkg::*;
;
    logic clk_in = 1'b0, reset_in = 1'b1, cmd_write_in, cfg_write_in;
    logic [7:0] cmd_data_in, cmd_read_data_out, gain_correction_out, offset_correction_out;
    logic [31:0] cfg_data_in, config_word_one_out;
    logic preload_function_enable_in, external_trigger_pin_in;
    logic init_pulse_in, serial_sensor_mode_in, index_event_in;
    logic vernier_fault_in, offset_fault_in, other_fault_in;
    logic [3:0] address_strap_in, bus_address_out;
    logic [2:0] abz_in, abz_out, abz_oe_out;
    trigger_mode_t trigger_mode_in;
    logic calibration_refresh_out, vernier_recompute_out, store_settings_out;
    logic chip_reinit_out, config_reload_out, index_seen_flag_out, measurement_start_out;
    logic correction_loop_reset_out, counter_reload_out, clear_faults_out;
    logic vernier_fault_out, offset_fault_out, error_out;
    logic [7:0] obs;
    logic [7:0] exp_obs;
    int err_total = 0;
    int checked = 0;

    always #2 clk_in = ~clk_in;

    host_port_model host (.clk_in, .cmd_write_out(cmd_write_in), .cmd_data_out(cmd_data_in),
        .cfg_write_out(cfg_write_in), .cfg_data_out(cfg_data_in));

    interpolator_command_strobes dut (.clk_in, .reset_in, .cmd_write_in, .cmd_data_in,
        .cmd_read_data_out, .cfg_write_in, .cfg_data_in, .config_word_one_out,
        .preload_function_enable_in, .external_trigger_pin_in, .address_strap_in,
        .init_pulse_in, .serial_sensor_mode_in, .trigger_mode_in, .index_event_in,
        .vernier_fault_in, .offset_fault_in, .other_fault_in, .abz_in,
        .calibration_refresh_out, .vernier_recompute_out, .bus_address_out,
        .store_settings_out, .chip_reinit_out, .config_reload_out, .index_seen_flag_out,
        .measurement_start_out, .correction_loop_reset_out, .gain_correction_out,
        .offset_correction_out, .counter_reload_out, .clear_faults_out,
        .vernier_fault_out, .offset_fault_out, .error_out, .abz_out, .abz_oe_out);

    assign obs = {calibration_refresh_out, vernier_recompute_out, clear_faults_out,
        store_settings_out, chip_reinit_out, measurement_start_out,
        correction_loop_reset_out, counter_reload_out};

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask

    task automatic stop_test();
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        stop_test();
    end

    initial
    begin
        preload_function_enable_in <= 1'b1;
        external_trigger_pin_in <= 1'b0;
        init_pulse_in <= 1'b0;
        serial_sensor_mode_in <= 1'b0;
        index_event_in <= 1'b0;
        vernier_fault_in <= 1'b0;
        offset_fault_in <= 1'b0;
        other_fault_in <= 1'b0;
        address_strap_in <= 4'ha;
        abz_in <= 3'h0;
        trigger_mode_in <= TRIG_ADJUST_Z;
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        step();
        chk(config_word_one_out, CFG_ONE_RESET);
        chk({gain_correction_out, offset_correction_out, bus_address_out}, 20'h80800);
        host.send_cfg(32'h20f7_0000);
        step();
        chk(config_word_one_out, 32'h20f7_0000);
        @(posedge clk_in);
        offset_fault_in <= 1'b1;
        @(posedge clk_in);
        offset_fault_in <= 1'b0;
        step();
        chk(offset_fault_out, 1'b1);
        host.send_cmd(8'h00);
        #1 chk(obs, 8'h00);
        for (int b = 7; b >= 0; b--)
        begin
            exp_obs = (b == 5) ? 8'h00 : 8'h01 << b;
            if (b == 0)
                exp_obs = exp_obs | 8'h24;
            host.send_cmd(8'h01 << b);
            #1 chk(obs, exp_obs);
            chk(cmd_read_data_out, 8'h00);
            step();
            chk(obs, 8'h00);
            chk(config_reload_out, b == 3);
            if (b == 5)
                chk(bus_address_out, 4'ha);
            if (b == 3)
                chk(config_word_one_out, CFG_ONE_RESET);
            if (b == 1)
                chk({gain_correction_out, offset_correction_out}, 16'h8080);
        end
        for (int c = 2; c >= 0; c -= 2)
        begin
            @(posedge clk_in);
            index_event_in <= 1'b1;
            @(posedge clk_in);
            index_event_in <= 1'b0;
            #1 chk(index_seen_flag_out, 1'b1);
            host.send_cmd(8'h01 << c);
            step();
            chk(index_seen_flag_out, 1'b0);
        end
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk_in);
            trigger_mode_in <= trigger_mode_t'(m);
            host.send_cmd(8'h04);
            #1 chk(measurement_start_out, m >= 2);
        end
        @(posedge clk_in);
        address_strap_in <= 4'h5;
        serial_sensor_mode_in <= 1'b1;
        init_pulse_in <= 1'b1;
        preload_function_enable_in <= 1'b0;
        external_trigger_pin_in <= 1'b1;
        @(posedge clk_in);
        init_pulse_in <= 1'b0;
        #1 chk(bus_address_out, 4'h5);
        chk(calibration_refresh_out, 1'b1);
        host.send_cmd(8'h40);
        #1 chk(vernier_recompute_out, 1'b0);
        external_trigger_pin_in <= 1'b0;
        host.send_cfg(32'h40f7_0000);
        @(posedge clk_in);
        vernier_fault_in <= 1'b1;
        offset_fault_in <= 1'b1;
        abz_in <= 3'h5;
        @(posedge clk_in);
        vernier_fault_in <= 1'b0;
        offset_fault_in <= 1'b0;
        step();
        chk({vernier_fault_out, offset_fault_out, error_out}, 3'b101);
        host.send_cmd(8'h01);
        step();
        step();
        chk({vernier_fault_out, abz_out, abz_oe_out}, 7'h2f);
        @(posedge clk_in);
        other_fault_in <= 1'b1;
        abz_in <= 3'h2;
        step();
        step();
        chk({abz_out, abz_oe_out}, 6'h2f);
        host.send_cfg(32'h80f7_0000);
        step();
        step();
        chk(abz_oe_out, 3'h0);
        @(posedge clk_in);
        other_fault_in <= 1'b0;
        step();
        step();
        chk({abz_out, abz_oe_out}, 6'h17);
        stop_test();
    end
endmodule

`default_nettype wire
